// >>> sifd_clamp.sv
// Saturating clamp of a signed preset speed to the preset range.
// Assumes a signed value in rpm at the top-level width.
`timescale 1ns/1ps
`include "sifd_consts.svh"
module sifd_clamp #(
  parameter int W = 16
) (
  // Value in and out
  input  wire logic signed [W-1:0] val_i,
  output wire logic signed [W-1:0] val_o
);
  // Limit to the preset span
  assign val_o = (val_i > W'(`SIFD_PRESET_MAX)) ? W'(`SIFD_PRESET_MAX) :
                 (val_i < W'(`SIFD_PRESET_MIN)) ? W'(`SIFD_PRESET_MIN) : val_i;
endmodule : sifd_clamp

// >>> sifd_consts.svh
// Constants for the servo input function decoder.
// Assumes inclusion by bare name; definitions only.
`ifndef SIFD_CONSTS_SVH
`define SIFD_CONSTS_SVH
// ----------------------------------------
// Function codes
// ----------------------------------------
`define SIFD_FC_W        6
`define SIFD_FC_NONE     6'h00
`define SIFD_FC_RSV8     6'h08
`define SIFD_FC_TRQLIM   6'h09
`define SIFD_FC_SPDLIM   6'h0A
`define SIFD_FC_GEARSEL  6'h0B
`define SIFD_FC_RSV12    6'h0C
`define SIFD_FC_RSV13    6'h0D
`define SIFD_FC_SPDB0    6'h0E
`define SIFD_FC_SPDB1    6'h0F
// ----------------------------------------
// Limits and zero command
// ----------------------------------------
`define SIFD_PRESET_MAX  16'sh1388
`define SIFD_PRESET_MIN  -16'sh1388
`define SIFD_CMD_ZERO    16'sh0000
`endif

// >>> sifd_ctrl_model.sv
// Model of the motion controller that drives the discrete input lines.
// Assumes the bench commands line levels and code assignments between edges.
`timescale 1ns/1ps
module sifd_ctrl_model (
  // Commands from the bench
  input  wire logic [5:0]  lvl_i,
  input  wire logic [35:0] code_i,
  // Lines into the drive
  output logic [5:0]       di_level_o,
  output logic [35:0]      assign_o
);
  // Lines are level sensitive, so they are held steady with no strobe
  assign di_level_o = lvl_i;
  assign assign_o   = code_i;
endmodule : sifd_ctrl_model

// >>> sifd_decoder.sv
// Decoder of general input function codes for a servo drive.
// Assumes inputs synchronous to sys_clk_i and debounced outside.
`timescale 1ns/1ps
`include "sifd_consts.svh"
module sifd_decoder #(
  parameter int N_IN = 6,
  parameter int W    = 16
) (
  // Clock, reset, enable
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  clk_en_i,
  // Discrete inputs and their function assignments
  input  wire logic [N_IN-1:0]       di_level_i,
  input  wire logic [N_IN*6-1:0]     input_function_assignment_i,
  // Mode
  input  wire sifd_pkg::sifd_mode_e  mode_i,
  input  wire logic                  zero_speed_submode_i,
  // Limit sources
  input  wire logic                  trq_lim_src_analog_i,
  input  wire logic signed [W-1:0]   trq_lim_param_i,
  input  wire logic                  spd_lim_src_analog_i,
  input  wire logic signed [W-1:0]   spd_lim_param_i,
  input  wire logic signed [W-1:0]   analog_ref_i,
  // Gear numerators
  input  wire logic [W-1:0]          first_numerator_setting_i,
  input  wire logic [W-1:0]          second_numerator_setting_i,
  // Speed presets
  input  wire logic signed [W-1:0]   preset_speed_two_i,
  input  wire logic signed [W-1:0]   preset_speed_three_i,
  input  wire logic signed [W-1:0]   preset_speed_four_i,
  // Decoded outputs
  output logic                       torque_limit_on_o,
  output logic signed [W-1:0]        torque_limit_o,
  output logic                       speed_limit_on_o,
  output logic signed [W-1:0]        speed_limit_o,
  output logic [W-1:0]               gear_numerator_o,
  output logic [1:0]                 speed_select_o,
  output logic [2:0]                 speed_src_o,
  output logic signed [W-1:0]        speed_cmd_o
);

  // ----------------------------------------
  // Function decode
  // ----------------------------------------
  // True when input i carries code fc and is active
  function automatic logic fn_active(input logic [N_IN*6-1:0] asg, input logic [N_IN-1:0] lvl,
                                     input logic [5:0] fc);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < N_IN; i++) begin
      if (fc != `SIFD_FC_NONE && asg[i*`SIFD_FC_W +: `SIFD_FC_W] == fc && lvl[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : fn_active

  // reserved codes are never decoded, so they do nothing
  wire logic torque_limit_enable_in   = fn_active(input_function_assignment_i, di_level_i, `SIFD_FC_TRQLIM);
  wire logic speed_limit_enable_in    = fn_active(input_function_assignment_i, di_level_i, `SIFD_FC_SPDLIM);
  wire logic gear_numerator_select_in = fn_active(input_function_assignment_i, di_level_i, `SIFD_FC_GEARSEL);
  wire logic speed_select_bit0        = fn_active(input_function_assignment_i, di_level_i, `SIFD_FC_SPDB0);
  wire logic speed_select_bit1        = fn_active(input_function_assignment_i, di_level_i, `SIFD_FC_SPDB1);

  // ----------------------------------------
  // Command selection
  // ----------------------------------------
  // torque limit only in position or speed mode
  wire logic trq_on_d = torque_limit_enable_in && (mode_i != sifd_pkg::SIFD_MODE_TRQ);
  // speed limit only in torque mode
  wire logic spd_on_d = speed_limit_enable_in && (mode_i == sifd_pkg::SIFD_MODE_TRQ);
  wire logic signed [W-1:0] trq_val_d = trq_lim_src_analog_i ? analog_ref_i : trq_lim_param_i;
  wire logic signed [W-1:0] spd_val_d = spd_lim_src_analog_i ? analog_ref_i : spd_lim_param_i;
  // gear numerator in position mode; other modes hold the first
  wire logic [W-1:0] gear_d = (gear_numerator_select_in && mode_i == sifd_pkg::SIFD_MODE_POS)
                              ? second_numerator_setting_i : first_numerator_setting_i;
  wire logic [1:0] sel_d = {speed_select_bit1, speed_select_bit0};

  // Presets clamped once each; a generate keeps the three paths alike
  wire logic signed [W-1:0] preset_raw [3];
  wire logic signed [W-1:0] preset_lim [3];
  assign preset_raw[0] = preset_speed_two_i;
  assign preset_raw[1] = preset_speed_three_i;
  assign preset_raw[2] = preset_speed_four_i;
  for (genvar g = 0; g < 3; g++) begin : g_clamp
    sifd_clamp #(.W(W)) u_clamp (
      .val_i (preset_raw[g]),
      .val_o (preset_lim[g])
    );
  end

  // selector 00 normal takes the analog reference
  // selector 00 zero-speed submode forces zero
  wire sifd_pkg::sifd_src_e src_d =
      (sel_d == 2'h0) ? (zero_speed_submode_i ? sifd_pkg::SIFD_SRC_ZERO : sifd_pkg::SIFD_SRC_ANALOG) :
      (sel_d == 2'h1) ? sifd_pkg::SIFD_SRC_P2 :
      (sel_d == 2'h2) ? sifd_pkg::SIFD_SRC_P3 : sifd_pkg::SIFD_SRC_P4;
  logic signed [W-1:0] cmd_d;
  always_comb begin
    case (src_d)
      sifd_pkg::SIFD_SRC_ANALOG: cmd_d = analog_ref_i;
      sifd_pkg::SIFD_SRC_ZERO:   cmd_d = W'(`SIFD_CMD_ZERO);
      sifd_pkg::SIFD_SRC_P2:     cmd_d = preset_lim[0];
      sifd_pkg::SIFD_SRC_P3:     cmd_d = preset_lim[1];
      sifd_pkg::SIFD_SRC_P4:     cmd_d = preset_lim[2];
      default:                   cmd_d = W'(`SIFD_CMD_ZERO);
    endcase
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  // One cycle of latency so every output comes from a flop
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      torque_limit_on_o <= 1'b0;
      torque_limit_o    <= '0;
      speed_limit_on_o  <= 1'b0;
      speed_limit_o     <= '0;
      gear_numerator_o  <= '0;
      speed_select_o    <= 2'h0;
      speed_src_o       <= 3'h0;
      speed_cmd_o       <= '0;
    end else if (clk_en_i) begin
      torque_limit_on_o <= trq_on_d;
      torque_limit_o    <= trq_on_d ? trq_val_d : W'(`SIFD_CMD_ZERO);
      speed_limit_on_o  <= spd_on_d;
      speed_limit_o     <= spd_on_d ? spd_val_d : W'(`SIFD_CMD_ZERO);
      gear_numerator_o  <= gear_d;
      speed_select_o    <= sel_d;
      speed_src_o       <= src_d;
      speed_cmd_o       <= cmd_d;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_trq_req;
    clk_en_i && torque_limit_enable_in && mode_i != sifd_pkg::SIFD_MODE_TRQ;
  endsequence
  torque_limit_gate_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_trq_req |=> torque_limit_on_o) else $error("torque limit not applied");
  torque_limit_off_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (clk_en_i && !torque_limit_enable_in) |=> !torque_limit_on_o && torque_limit_o == 0)
    else $error("torque limit applied while off");
  torque_source_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (s_trq_req and trq_lim_src_analog_i) |=> torque_limit_o == $past(analog_ref_i))
    else $error("torque limit source wrong");
  speed_limit_mode_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (clk_en_i && mode_i != sifd_pkg::SIFD_MODE_TRQ) |=> !speed_limit_on_o)
    else $error("speed limit outside torque mode");
  speed_lim_source_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (clk_en_i && spd_on_d && !spd_lim_src_analog_i) |=> speed_limit_o == $past(spd_lim_param_i))
    else $error("speed limit source wrong");
  gear_select_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (clk_en_i && mode_i == sifd_pkg::SIFD_MODE_POS && gear_numerator_select_in)
    |=> gear_numerator_o == $past(second_numerator_setting_i)) else $error("gear numerator wrong");
  zero_speed_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (clk_en_i && sel_d == 2'h0 && zero_speed_submode_i) |=> speed_cmd_o == 0)
    else $error("zero speed not forced");
  analog_speed_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (clk_en_i && sel_d == 2'h0 && !zero_speed_submode_i) |=> speed_cmd_o == $past(analog_ref_i))
    else $error("analog speed not used");
  preset_range_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (speed_src_o != sifd_pkg::SIFD_SRC_ANALOG && speed_src_o != sifd_pkg::SIFD_SRC_ZERO)
    |-> speed_cmd_o <= W'(`SIFD_PRESET_MAX) && speed_cmd_o >= W'(`SIFD_PRESET_MIN))
    else $error("preset out of range");
  selector_level_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    clk_en_i |=> speed_select_o == $past(sel_d)) else $error("selector not sampled");
  freeze_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    !clk_en_i |=> $stable(speed_cmd_o) && $stable(torque_limit_on_o)) else $error("state moved while frozen");

endmodule : sifd_decoder

// >>> sifd_pkg.sv
// Types for the servo input function decoder.
// Assumes no other package.
package sifd_pkg;
  // Control mode of the drive
  typedef enum logic [1:0] {
    SIFD_MODE_POS = 2'b00,
    SIFD_MODE_SPD = 2'b01,
    SIFD_MODE_TRQ = 2'b10
  } sifd_mode_e;
  // Speed command source after selection
  typedef enum logic [2:0] {
    SIFD_SRC_ANALOG = 3'b000,
    SIFD_SRC_ZERO   = 3'b001,
    SIFD_SRC_P2     = 3'b010,
    SIFD_SRC_P3     = 3'b011,
    SIFD_SRC_P4     = 3'b100
  } sifd_src_e;
endpackage : sifd_pkg

// >>> tb_top.sv
// Self-checking bench for the input function decoder.
// Assumes one 100 MHz clock and a one-cycle registered answer.
`timescale 1ns/1ps
`include "sifd_consts.svh"
module tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic                 sys_clk_i = 1'b0;
  logic                 rst_i     = 1'b1;
  logic                 clk_en_i  = 1'b1;
  logic [5:0]           lvl       = 6'h00;
  logic [35:0]          codes     = 36'h0;
  logic [5:0]           di;
  logic [35:0]          fa;
  sifd_pkg::sifd_mode_e mode      = sifd_pkg::SIFD_MODE_POS;
  logic                 zs = 1'b0, tsa = 1'b0, ssa = 1'b0;
  logic signed [15:0]   tp = 16'h0, sp = 16'h0, an = 16'h0, p2 = 16'h0, p3 = 16'h0, p4 = 16'h0;
  logic [15:0]          n1 = 16'h0, n2 = 16'h0, gn;
  logic                 to, so;
  logic signed [15:0]   tv, sv, cmd;
  logic [1:0]           sel;
  logic [2:0]           src;
  logic [70:0]          exp_q[$];
  logic [70:0]          last = 71'h0;
  logic [31:0]          rng  = 32'h2E;
  int                   n_fail = 0, total_checks = 0;
  logic [5:0]           tbl[9] = '{6'h00, 6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F};

  always #5 sys_clk_i = ~sys_clk_i;

  sifd_ctrl_model ctrl (.lvl_i(lvl), .code_i(codes), .di_level_o(di), .assign_o(fa));
  sifd_decoder #(.N_IN(6), .W(16)) dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
    .di_level_i(di), .input_function_assignment_i(fa), .mode_i(mode), .zero_speed_submode_i(zs),
    .trq_lim_src_analog_i(tsa), .trq_lim_param_i(tp), .spd_lim_src_analog_i(ssa), .spd_lim_param_i(sp),
    .analog_ref_i(an), .first_numerator_setting_i(n1), .second_numerator_setting_i(n2),
    .preset_speed_two_i(p2), .preset_speed_three_i(p3), .preset_speed_four_i(p4),
    .torque_limit_on_o(to), .torque_limit_o(tv), .speed_limit_on_o(so), .speed_limit_o(sv),
    .gear_numerator_o(gn), .speed_select_o(sel), .speed_src_o(src), .speed_cmd_o(cmd));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[15:0];
  endfunction : rnd

  // Presets saturate rather than wrap, so a large setting stays safe
  function automatic logic signed [15:0] clamp(input logic signed [15:0] v);
    if (v > `SIFD_PRESET_MAX) return `SIFD_PRESET_MAX;
    if (v < `SIFD_PRESET_MIN) return `SIFD_PRESET_MIN;
    return v;
  endfunction : clamp

  task automatic chk(input string nm, input logic [70:0] e, input logic [70:0] s);
    total_checks++;
    if (e !== s) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // Random inputs, with codes drawn from a table holding every handled code
  task automatic step();
    logic a9, a10, a11, a14, a15;
    logic [2:0] es;
    logic signed [15:0] ec;
    {a9, a10, a11, a14, a15} = 5'h00;
    lvl = 6'(rnd());
    for (int i = 0; i < 6; i++) codes[i*6 +: 6] = tbl[rnd() % 9];
    mode = sifd_pkg::sifd_mode_e'(rnd() % 3);
    {zs, tsa, ssa} = 3'(rnd());
    {tp, sp, an, p2, p3, p4, n1, n2} = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
    clk_en_i = (rnd() % 8) != 0;
    for (int i = 0; i < 6; i++) begin
      a9  |= lvl[i] && codes[i*6 +: 6] == 6'h09;
      a10 |= lvl[i] && codes[i*6 +: 6] == 6'h0A;
      a11 |= lvl[i] && codes[i*6 +: 6] == 6'h0B;
      a14 |= lvl[i] && codes[i*6 +: 6] == 6'h0E;
      a15 |= lvl[i] && codes[i*6 +: 6] == 6'h0F;
    end
    es = ({a15, a14} == 2'h0) ? {2'h0, zs} : 3'({a15, a14}) + 3'h1;
    ec = (es == 3'h0) ? an : (es == 3'h1) ? 16'sh0 : clamp(es == 3'h2 ? p2 : es == 3'h3 ? p3 : p4);
    if (clk_en_i) begin
      last = {a9 && mode != sifd_pkg::SIFD_MODE_TRQ, 16'h0, a10 && mode == sifd_pkg::SIFD_MODE_TRQ, 16'h0,
              (a11 && mode == sifd_pkg::SIFD_MODE_POS) ? n2 : n1, a15, a14, es, ec};
      if (last[70]) last[69:54] = tsa ? an : tp;
      if (last[53]) last[52:37] = ssa ? an : sp;
    end
    exp_q.push_back(last);
  endtask : step

  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // ----------------------------------------
  // Monitor: a note pushed one edge earlier is due now
  // ----------------------------------------
  always @(negedge sys_clk_i) begin
    if (exp_q.size() >= 2) begin
      logic [70:0] e;
      logic [70:0] s;
      e = exp_q.pop_front();
      s = {to, tv, so, sv, gn, sel, src, cmd};
      chk("limits", 71'(e[70:37]), 71'(s[70:37]));
      chk("gear", 71'(e[36:21]), 71'(s[36:21]));
      chk("speed", 71'(e[20:0]), 71'(s[20:0]));
    end
  end

  // Main sequence: reset, check cleared outputs, then random traffic
  initial begin
    repeat (4) @(posedge sys_clk_i);
    #1 rst_i = 1'b0;
    @(negedge sys_clk_i);
    chk("reset", 71'h0, {to, tv, so, sv, gn, sel, src, cmd});
    repeat (600) begin
      @(posedge sys_clk_i);
      #1 step();
    end
    repeat (3) @(posedge sys_clk_i);
    conclude();
  end

  // Watchdog well beyond the 600-cycle run
  initial begin
    #20000;
    n_fail++;
    conclude();
  end
endmodule : tb_top
